/* File: design/smlu_core.sv */
// Purpose: scalar multiply and logic execution with its register file
// Assumes: one instruction per cycle, all writes done at the clock edge
// Notes:   software reaches registers, status, mask and flag on a plain port
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module smlu_core #(
    parameter int unsigned NUM_REGS = 16
) (
    input  wire logic                   clk_sys_i,
    input  wire logic                   rst_b_i,
    input  wire logic                   instr_valid_i,
    input  wire smlu_pkg::smlu_instr_t  instr_i,
    input  wire smlu_pkg::smlu_bus_req_t bus_req_i,
    output logic [31:0]                 bus_rdata_o,
    output logic                        done_o,
    output logic                        high_flag_o,
    output logic                        irq_o
);

    // =========================================================
    // functions
    function automatic logic [31:0] smlu_zext(input logic [15:0] lit);
        smlu_zext = {16'h0000, lit};
    endfunction : smlu_zext

    function automatic logic [31:0] smlu_cond_inv(input logic [31:0] v, input logic inv);
        smlu_cond_inv = inv ? ~v : v;
    endfunction : smlu_cond_inv

    // =========================================================
    // storage
    logic [31:0] regs_ff [NUM_REGS];
    logic [2:0]  status_ff;
    logic [2:0]  mask_ff;
    logic        flag_ff;
    logic        done_ff;
    logic [31:0] rdata_ff;

    // =========================================================
    // operand fetch and execute
    logic [31:0] first_raw;
    logic [31:0] second_raw;
    logic [31:0] opa;
    logic [31:0] opb;
    logic [31:0] lit_ext;
    logic [63:0] product;
    logic [31:0] nxt_lo;
    logic [3:0]  hi_idx;
    logic        wr_lo;
    logic        wr_hi;
    logic        set_flag;
    logic        refused;

    assign first_raw  = regs_ff[instr_i.result_reg_field];
    assign second_raw = regs_ff[instr_i.second_reg_field];
    assign opa        = smlu_cond_inv(first_raw, instr_i.inv_first);
    assign opb        = smlu_cond_inv(second_raw, instr_i.inv_second);
    assign lit_ext    = smlu_zext(instr_i.literal);
    assign product    = {32'h0000_0000, first_raw} * {32'h0000_0000, second_raw};
    assign hi_idx     = instr_i.result_reg_field - 4'h1;

    always_comb begin
        nxt_lo   = first_raw;
        wr_lo    = 1'b0;
        wr_hi    = 1'b0;
        set_flag = 1'b0;
        refused  = 1'b0;
        case (instr_i.opcode)
            smlu_pkg::OPC_MUL_LOW: begin
                nxt_lo = product[31:0];
                wr_lo  = 1'b1;
            end
            smlu_pkg::OPC_MUL_LOW_FLAGGED: begin
                nxt_lo   = product[31:0];
                wr_lo    = 1'b1;
                set_flag = 1'b1;
            end
            smlu_pkg::OPC_MUL_WIDE: begin
                if (instr_i.result_reg_field >= smlu_pkg::WIDE_MIN_IDX
                        && instr_i.result_reg_field <= smlu_pkg::WIDE_MAX_IDX) begin
                    nxt_lo = product[31:0];
                    wr_lo  = 1'b1;
                    wr_hi  = 1'b1;
                end else begin
                    refused = 1'b1;
                end
            end
            smlu_pkg::OPC_NAND_REGS: begin
                nxt_lo = ~(opa & opb);
                wr_lo  = 1'b1;
            end
            smlu_pkg::OPC_NOT_AND_LITERAL: begin
                nxt_lo = ~(opa & lit_ext);
                wr_lo  = 1'b1;
            end
            smlu_pkg::OPC_NOT_AND_INV_LIT: begin
                nxt_lo = ~(opa & ~lit_ext);
                wr_lo  = 1'b1;
            end
            smlu_pkg::OPC_XOR_REGS: begin
                nxt_lo = first_raw ^ second_raw;
                wr_lo  = 1'b1;
            end
            smlu_pkg::OPC_XOR_REG_LITERAL: begin
                nxt_lo = first_raw ^ lit_ext;
                wr_lo  = 1'b1;
            end
            smlu_pkg::OPC_NOR_REGS: begin
                nxt_lo = ~(opa | opb);
                wr_lo  = 1'b1;
            end
            default: begin
                refused = 1'b1;
            end
        endcase
    end

    logic exec;
    logic exec_ok;
    logic [2:0] st_set;
    logic [2:0] st_clr;
    logic       bus_wr_reg;

    assign exec       = instr_valid_i;
    assign exec_ok    = exec && !refused;
    assign bus_wr_reg = bus_req_i.wr && bus_req_i.addr <= smlu_pkg::REGFILE_END
                        && bus_req_i.addr[1:0] == 2'b00;

    // =========================================================
    // register file: instruction write wins over a bus write
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_ff[i] <= smlu_pkg::REG_RST;
            end
        end else begin
            if (bus_wr_reg) begin
                regs_ff[bus_req_i.addr[5:2]] <= bus_req_i.wdata;
            end
            if (exec && wr_hi) begin
                regs_ff[hi_idx] <= product[63:32];
            end
            if (exec && wr_lo) begin
                regs_ff[instr_i.result_reg_field] <= nxt_lo;
            end
        end
    end

    // =========================================================
    // high-bits flag
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            flag_ff <= smlu_pkg::FLAG_RST;
        end else if (exec && set_flag) begin
            flag_ff <= |product[63:32];
        end
    end

    // =========================================================
    // status, mask, interrupt
    assign st_set = {exec && refused, exec && set_flag && (|product[63:32]), exec_ok};
    assign st_clr = (bus_req_i.wr && bus_req_i.addr == smlu_pkg::STATUS_OFS) ? bus_req_i.wdata[2:0] : 3'h0;

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            status_ff <= smlu_pkg::STATUS_RST;
        end else begin
            status_ff <= (status_ff & ~st_clr) | st_set;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mask_ff <= smlu_pkg::MASK_RST;
        end else if (bus_req_i.wr && bus_req_i.addr == smlu_pkg::MASK_OFS) begin
            mask_ff <= bus_req_i.wdata[2:0];
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            done_ff <= 1'b0;
        end else begin
            done_ff <= exec_ok;
        end
    end

    // =========================================================
    // read port
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_ff <= 32'h0000_0000;
        end else if (bus_req_i.rd) begin
            if (bus_req_i.addr <= smlu_pkg::REGFILE_END && bus_req_i.addr[1:0] == 2'b00) begin
                rdata_ff <= regs_ff[bus_req_i.addr[5:2]];
            end else if (bus_req_i.addr == smlu_pkg::STATUS_OFS) begin
                rdata_ff <= {29'h0, status_ff};
            end else if (bus_req_i.addr == smlu_pkg::MASK_OFS) begin
                rdata_ff <= {29'h0, mask_ff};
            end else if (bus_req_i.addr == smlu_pkg::FLAG_OFS) begin
                rdata_ff <= {31'h0, flag_ff};
            end else begin
                rdata_ff <= 32'h0000_0000;
            end
        end else begin
            rdata_ff <= 32'h0000_0000;
        end
    end

    assign bus_rdata_o = rdata_ff;
    assign done_o      = done_ff;
    assign high_flag_o = flag_ff;
    assign irq_o       = |(status_ff & mask_ff);

    // =========================================================
    // checks
    a_mul_low_word: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        exec && instr_i.opcode == smlu_pkg::OPC_MUL_LOW
        |=> regs_ff[$past(instr_i.result_reg_field)] == $past(product[31:0]))
        else $error("low multiply wrote a wrong word");

    a_flag_from_high: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        exec && instr_i.opcode == smlu_pkg::OPC_MUL_LOW_FLAGGED
        |=> high_flag_o == ($past(first_raw) * $past(second_raw) > 64'h0000_0000_ffff_ffff))
        else $error("flag does not match high product bits");

    a_wide_high_word: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        exec_ok && instr_i.opcode == smlu_pkg::OPC_MUL_WIDE
        |=> regs_ff[$past(instr_i.result_reg_field) - 4'h1] == $past(product[63:32])
            && regs_ff[$past(instr_i.result_reg_field)] == $past(product[31:0]))
        else $error("wide multiply result misplaced");

    a_wide_zero_refused: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        exec && instr_i.opcode == smlu_pkg::OPC_MUL_WIDE && instr_i.result_reg_field == 4'h0
        && !bus_req_i.wr |=> $stable(regs_ff[0]) && status_ff[smlu_pkg::ST_REFUSED_BIT] && !done_o)
        else $error("wide multiply into register zero not refused");

    a_second_kept: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        exec && instr_i.opcode == smlu_pkg::OPC_NAND_REGS && !bus_req_i.wr
        && instr_i.second_reg_field != instr_i.result_reg_field
        |=> regs_ff[$past(instr_i.second_reg_field)] == $past(second_raw))
        else $error("second source register was changed");

    a_nand_regs: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        exec && instr_i.opcode == smlu_pkg::OPC_NAND_REGS
        |=> regs_ff[$past(instr_i.result_reg_field)]
            == ~(($past(instr_i.inv_first) ? ~$past(first_raw) : $past(first_raw))
               & ($past(instr_i.inv_second) ? ~$past(second_raw) : $past(second_raw))))
        else $error("register nand result wrong");

    a_nand_literal: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        exec && instr_i.opcode == smlu_pkg::OPC_NOT_AND_LITERAL
        |=> regs_ff[$past(instr_i.result_reg_field)][31:16] == 16'hffff
            && regs_ff[$past(instr_i.result_reg_field)][15:0]
               == ~($past(opa[15:0]) & $past(instr_i.literal)))
        else $error("literal nand result wrong");

    a_nand_inv_lit: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        exec && instr_i.opcode == smlu_pkg::OPC_NOT_AND_INV_LIT
        |=> regs_ff[$past(instr_i.result_reg_field)][31:16] == ~$past(opa[31:16]))
        else $error("inverted literal upper bits wrong");

    a_xor_regs: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        exec && instr_i.opcode == smlu_pkg::OPC_XOR_REGS
        |=> regs_ff[$past(instr_i.result_reg_field)] == ($past(first_raw) ^ $past(second_raw)))
        else $error("register xor result wrong");

    a_xor_literal: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        exec && instr_i.opcode == smlu_pkg::OPC_XOR_REG_LITERAL
        |=> regs_ff[$past(instr_i.result_reg_field)] == ($past(first_raw) ^ {16'h0000, $past(instr_i.literal)}))
        else $error("literal xor result wrong");

    a_nor_regs: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        exec && instr_i.opcode == smlu_pkg::OPC_NOR_REGS
        |=> regs_ff[$past(instr_i.result_reg_field)] == ~($past(opa) | $past(opb)))
        else $error("register nor result wrong");

    a_flag_kept: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        !(exec && instr_i.opcode == smlu_pkg::OPC_MUL_LOW_FLAGGED) |=> $stable(high_flag_o))
        else $error("flag changed without flagged multiply");

    a_irq_level: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        exec_ok ##1 mask_ff[smlu_pkg::ST_DONE_BIT] |-> irq_o && done_o)
        else $error("done event did not raise interrupt");

endmodule : smlu_core

`default_nettype wire

/* File: design/smlu_pkg.sv */
// Purpose: shared constants and types of the scalar multiply and logic unit
// Assumes: 32-bit scalar registers, sixteen of them, 4-bit register fields
// Notes:   offsets are byte addresses on the plain register port
`default_nettype none
package smlu_pkg;
    // =========================================================
    // widths
    localparam int unsigned DATA_W  = 32;
    localparam int unsigned IDX_W   = 4;
    localparam int unsigned LIT_W   = 16;
    localparam int unsigned OPC_W   = 4;
    localparam int unsigned ADDR_W  = 8;
    localparam int unsigned ST_W    = 3;

    // =========================================================
    // opcodes
    localparam logic [3:0] OPC_MUL_LOW          = 4'h1;
    localparam logic [3:0] OPC_MUL_LOW_FLAGGED  = 4'h2;
    localparam logic [3:0] OPC_MUL_WIDE         = 4'h3;
    localparam logic [3:0] OPC_NAND_REGS        = 4'h4;
    localparam logic [3:0] OPC_NOT_AND_LITERAL  = 4'h5;
    localparam logic [3:0] OPC_NOT_AND_INV_LIT  = 4'h6;
    localparam logic [3:0] OPC_XOR_REGS         = 4'h7;
    localparam logic [3:0] OPC_XOR_REG_LITERAL  = 4'h8;
    localparam logic [3:0] OPC_NOR_REGS         = 4'h9;

    // legal first operand range of the wide multiply
    localparam logic [3:0] WIDE_MIN_IDX = 4'h1;
    localparam logic [3:0] WIDE_MAX_IDX = 4'hd;

    // =========================================================
    // register port map
    localparam logic [7:0] REGFILE_OFS  = 8'h00;
    localparam logic [7:0] REGFILE_END  = 8'h3c;
    localparam logic [7:0] STATUS_OFS   = 8'h40;
    localparam logic [7:0] MASK_OFS     = 8'h44;
    localparam logic [7:0] FLAG_OFS     = 8'h48;

    // status and mask bit positions
    localparam int unsigned ST_DONE_BIT    = 0;
    localparam int unsigned ST_FLAG_BIT    = 1;
    localparam int unsigned ST_REFUSED_BIT = 2;

    // reset values
    localparam logic [31:0] REG_RST    = 32'h0000_0000;
    localparam logic [2:0]  STATUS_RST = 3'h0;
    localparam logic [2:0]  MASK_RST   = 3'h0;
    localparam logic        FLAG_RST   = 1'b0;

    // =========================================================
    // carriers
    typedef struct packed {
        logic [3:0]  opcode;
        logic [3:0]  result_reg_field;
        logic [3:0]  second_reg_field;
        logic        inv_first;
        logic        inv_second;
        logic [15:0] literal;
    } smlu_instr_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } smlu_bus_req_t;
endpackage : smlu_pkg
`default_nettype wire

/* File: dv/smlu_issuer.sv */
// Purpose: instruction issuer standing in for the decoder and register selector
// Assumes: one instruction per call, launched just after a rising edge
// Notes:   fields carry a toggling pattern while nothing is issued
`timescale 1ns/1ps
`default_nettype none
module smlu_issuer (
    input  wire logic                  clk_sys_i,
    output logic                       instr_valid_o,
    output wire smlu_pkg::smlu_instr_t instr_o
);
    smlu_pkg::smlu_instr_t held;
    smlu_pkg::smlu_instr_t idle_pat;
    initial begin
        instr_valid_o = 1'b0;
        held = '0;
        idle_pat = '0;
    end
    always @(posedge clk_sys_i) begin
        idle_pat <= ~idle_pat;
    end
    assign instr_o = instr_valid_o ? held : idle_pat;
    // =========================================================
    // issue one instruction, keep valid up unless last; an out-of-range wide multiply is held back unless bad
    task automatic issue(input smlu_pkg::smlu_instr_t ins, input logic last, input logic bad);
        if (!bad && ins.opcode == smlu_pkg::OPC_MUL_WIDE && (ins.result_reg_field < smlu_pkg::WIDE_MIN_IDX
            || ins.result_reg_field > smlu_pkg::WIDE_MAX_IDX)) begin
            instr_valid_o <= 1'b0;
        end else begin
            instr_valid_o <= 1'b1;
        end
        held <= ins;
        @(posedge clk_sys_i);
        if (last) begin
            instr_valid_o <= 1'b0;
        end
    endtask : issue
endmodule : smlu_issuer
`default_nettype wire

/* File: dv/test_scalar_mul_logic_unit.sv */
// Purpose: self-checking bench of the scalar multiply and logic unit
// Assumes: 25 MHz clock, bus reads answer one cycle after the strobe
// Notes:   expected register contents kept in a local model
`timescale 1ns/1ps
`default_nettype none
module test_scalar_mul_logic_unit;
    logic                    clk_sys_i = 1'b0;
    logic                    rst_b_i   = 1'b0;
    smlu_pkg::smlu_bus_req_t bus_req   = '0;
    logic                    instr_valid;
    smlu_pkg::smlu_instr_t   instr;
    logic [31:0]             bus_rdata;
    logic                    done, high_flag, irq;
    logic [31:0]             m [16];
    logic                    flag = 1'b0;
    int                      err_count = 0;
    int                      cmp_count = 0;
    always #20 clk_sys_i = ~clk_sys_i;
    smlu_issuer u_smlu_issuer (.clk_sys_i(clk_sys_i), .instr_valid_o(instr_valid), .instr_o(instr));
    smlu_core u_smlu_core (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .instr_valid_i(instr_valid),
        .instr_i(instr), .bus_req_i(bus_req), .bus_rdata_o(bus_rdata), .done_o(done),
        .high_flag_o(high_flag), .irq_o(irq));
    // =========================================================
    // helpers
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys_i);
        bus_req <= '0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys_i);
        bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys_i);
        bus_req <= '0;
        #1 check($sformatf("rdata@%h", a), bus_rdata, exp);
    endtask : rd
    task automatic model(input smlu_pkg::smlu_instr_t i, output logic refused);
        logic [31:0] a, b, l;
        logic [63:0] p;
        a = i.inv_first ? ~m[i.result_reg_field] : m[i.result_reg_field];
        b = i.inv_second ? ~m[i.second_reg_field] : m[i.second_reg_field];
        l = {16'h0, i.literal};
        p = {32'h0, m[i.result_reg_field]} * {32'h0, m[i.second_reg_field]};
        refused = ((i.opcode == 4'h3) && (i.result_reg_field == 4'h0 || i.result_reg_field > 4'hd))
                  || i.opcode == 4'h0 || i.opcode > smlu_pkg::OPC_NOR_REGS;
        case (i.opcode)
            4'h1: m[i.result_reg_field] = p[31:0];
            4'h2: begin m[i.result_reg_field] = p[31:0]; flag = |p[63:32]; end
            4'h3: if (!refused) begin m[i.result_reg_field] = p[31:0]; m[i.result_reg_field - 1] = p[63:32]; end
            4'h4: m[i.result_reg_field] = ~(a & b);
            4'h5: m[i.result_reg_field] = ~(a & l);
            4'h6: m[i.result_reg_field] = ~(a & ~l);
            4'h7: m[i.result_reg_field] = m[i.result_reg_field] ^ m[i.second_reg_field];
            4'h8: m[i.result_reg_field] = m[i.result_reg_field] ^ l;
            4'h9: m[i.result_reg_field] = ~(a | b);
            default: ;
        endcase
    endtask : model
    task automatic run(input logic [3:0] op, r, s, input logic fi, si, input logic [15:0] lit);
        smlu_pkg::smlu_instr_t i;
        logic refused;
        i = '{opcode: op, result_reg_field: r, second_reg_field: s, inv_first: fi, inv_second: si, literal: lit};
        model(i, refused);
        @(posedge clk_sys_i);
        u_smlu_issuer.issue(i, 1'b1, 1'b1);
        #1 check("done", {31'h0, done}, {31'h0, !refused});
        rd({2'b00, r, 2'b00}, m[r]);
        rd({2'b00, r - 4'h1, 2'b00}, m[r - 4'h1]);
        rd(smlu_pkg::FLAG_OFS, {31'h0, flag});
        check("high_flag", {31'h0, high_flag}, {31'h0, flag});
    endtask : run
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        #800000;
        err_count++;
        report_and_stop();
    end
    // =========================================================
    // main sequence
    initial begin
        smlu_pkg::smlu_instr_t i1, i2;
        logic ref1;
        repeat (3) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        rd(8'h3c, 32'h0);
        rd(smlu_pkg::STATUS_OFS, 32'h0);
        rd(smlu_pkg::MASK_OFS, 32'h0);
        rd(smlu_pkg::FLAG_OFS, 32'h0);
        for (int k = 0; k < 16; k++) begin
            m[k] = 32'h9e37_79b9 * (k + 1);
            wr({2'b00, k[3:0], 2'b00}, m[k]);
        end
        run(4'h1, 4'h4, 4'h1, 1'b1, 1'b1, 16'h0);
        run(4'h2, 4'h5, 4'h6, 1'b0, 1'b0, 16'h0);
        for (int k = 0; k < 4; k++) begin
            run(4'h4, 4'h7, 4'h8, k[1], k[0], 16'h0);
            run(4'h9, 4'hd, 4'he, k[1], k[0], 16'h0);
        end
        for (int k = 0; k < 2; k++) begin
            run(4'h5, 4'h9, 4'h0, k[0], 1'b1, 16'h8001);
            run(4'h6, 4'ha, 4'h0, k[0], 1'b0, 16'h00f0);
        end
        run(4'h7, 4'hb, 4'hc, 1'b1, 1'b1, 16'h0);
        run(4'h8, 4'hc, 4'h0, 1'b1, 1'b1, 16'hbeef);
        run(4'h3, 4'h3, 4'h5, 1'b0, 1'b0, 16'h0);
        run(4'h3, 4'hd, 4'h2, 1'b0, 1'b0, 16'h0);
        run(4'h3, 4'h1, 4'h1, 1'b0, 1'b0, 16'h0);
        m[2] = 32'h3;
        m[6] = 32'h5;
        wr(8'h08, m[2]);
        wr(8'h18, m[6]);
        run(4'h2, 4'h2, 4'h6, 1'b0, 1'b0, 16'h0);
        wr(smlu_pkg::STATUS_OFS, 32'h7);
        wr(smlu_pkg::MASK_OFS, 32'h4);
        rd(smlu_pkg::MASK_OFS, 32'h4);
        run(4'h3, 4'h0, 4'h1, 1'b0, 1'b0, 16'h0);
        run(4'h3, 4'he, 4'h1, 1'b0, 1'b0, 16'h0);
        run(4'hf, 4'h2, 4'h3, 1'b0, 1'b0, 16'h0);
        rd(smlu_pkg::STATUS_OFS, 32'h4);
        check("irq", {31'h0, irq}, 32'h1);
        wr(smlu_pkg::STATUS_OFS, 32'h4);
        #1 check("irq", {31'h0, irq}, 32'h0);
        wr(smlu_pkg::FLAG_OFS, 32'h1);
        rd(smlu_pkg::FLAG_OFS, {31'h0, flag});
        rd(8'h80, 32'h0);
        i1 = '{opcode: 4'h1, result_reg_field: 4'h4, second_reg_field: 4'h1, inv_first: 1'b0, inv_second: 1'b0,
            literal: 16'h0};
        i2 = '{opcode: 4'h7, result_reg_field: 4'h4, second_reg_field: 4'h5, inv_first: 1'b0, inv_second: 1'b0,
            literal: 16'h0};
        model(i1, ref1);
        model(i2, ref1);
        @(posedge clk_sys_i);
        u_smlu_issuer.issue(i1, 1'b0, 1'b0);
        u_smlu_issuer.issue(i2, 1'b1, 1'b0);
        #1 check("done", {31'h0, done}, 32'h1);
        rd(8'h10, m[4]);
        // =========================================================
        // done event through mask bit 0
        wr(smlu_pkg::MASK_OFS, 32'h1);
        run(4'h7, 4'h4, 4'h5, 1'b0, 1'b0, 16'h0);
        check("irq", {31'h0, irq}, 32'h1);
        wr(smlu_pkg::STATUS_OFS, 32'h7);
        #1 check("irq", {31'h0, irq}, 32'h0);
        // =========================================================
        // mid-run reset
        @(posedge clk_sys_i);
        rst_b_i <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        rd(8'h10, 32'h0);
        rd(smlu_pkg::MASK_OFS, 32'h0);
        rd(smlu_pkg::STATUS_OFS, 32'h0);
        rd(smlu_pkg::FLAG_OFS, 32'h0);
        check("irq", {31'h0, irq}, 32'h0);
        report_and_stop();
    end
endmodule : test_scalar_mul_logic_unit
`default_nettype wire
